// ### rtl/eifp_pkg.sv
`default_nettype none
package eifp_pkg;
   localparam int POS_W           = 32;
   localparam int SPD_W           = 16;
   localparam int LSEL_W          = 2;
   localparam int CYC_NS          = 1000;
   localparam int CLK_NS          = 10;
   localparam int CYC_CLKS        = CYC_NS / CLK_NS;
   localparam int DIV_W           = 16;
   localparam logic [POS_W-1:0] POS_RST = 32'h0000_0000;

   typedef struct packed {
      logic                    feed_cmd;
      logic                    cancel;
      logic                    latch_request_first;
      logic [LSEL_W-1:0]       latch_signal_select_first;
      logic signed [SPD_W-1:0] speed;
   } eifp_cmd_t;

   typedef struct packed {
      logic                    latch_complete_first;
      logic                    motion_output_done_flag;
      logic                    cancel_done;
      logic                    busy;
   } eifp_stat_t;
endpackage
`default_nettype wire

// ### rtl/eifp_tick.sv
`default_nettype none
module eifp_tick #(
   parameter int DIV   = 100,
   parameter int DIV_W = 16
) (
   // Clock and reset
   input  wire logic mclk,
   input  wire logic sys_rst,
   // Cycle strobe
   output logic      tick
);
   logic [DIV_W-1:0] cnt_q, cnt_d;
   logic             tick_d;

   always_comb begin
      tick_d = (cnt_q == DIV_W'(DIV - 1));
      cnt_d  = tick_d ? '0 : cnt_q + 1'b1;
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cnt_q <= '0;
         tick  <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick  <= tick_d;
      end
   end
endmodule
`default_nettype wire

// ### rtl/eifp_feed.sv
// How it works
// - On the feed command the axis moves at the commanded speed.
// - Feeding starts together with waiting for the external positioning signal.
// - Positioning signal latches current position and sets latch complete.
// - Target equals latched position plus configured travel distance.
// - Done flag set once reference output reaches the target.
// - Cancel bit from master stops the feed.
// - Positive travel distance moves positive after latch, either prior direction.
// - Negative travel distance moves negative after latch, either prior direction.
`default_nettype none
module eifp_feed
   import eifp_pkg::*;
#(
   parameter int CYC_DIV = CYC_CLKS
) (
   // Clock and reset
   input  wire logic                    mclk,
   input  wire logic                    sys_rst,
   // Command from the network, on mclk
   input  wire eifp_pkg::eifp_cmd_t     cmd,
   input  wire logic signed [eifp_pkg::POS_W-1:0] travel_dist,
   // External positioning signals (pins)
   input  wire logic [3:0]              ext_sig,
   // Status and reference position
   output var eifp_pkg::eifp_stat_t     stat,
   output var logic signed [eifp_pkg::POS_W-1:0] ref_pos,
   output var logic signed [eifp_pkg::POS_W-1:0] latched_pos
);
   import eifp_pkg::*;

   typedef enum logic [1:0] {EIFP_IDLE, EIFP_FEED, EIFP_POSN} eifp_st_t;

   logic                    tick;
   logic [3:0]              sync1_q, sync2_q, sig_prev_q;
   eifp_st_t                st_q, st_d;
   logic signed [POS_W-1:0] pos_q, pos_d, tgt_q, tgt_d, lat_q, lat_d;
   logic signed [SPD_W-1:0] spd_q, spd_d;
   logic [LSEL_W-1:0]       sel_q, sel_d;
   eifp_stat_t              stat_q, stat_d;
   logic                    edge_hit;
   logic signed [POS_W-1:0] diff, step;

   eifp_tick #(.DIV(CYC_DIV), .DIV_W(DIV_W)) u_tick (
      .mclk    (mclk),
      .sys_rst (sys_rst),
      .tick    (tick)
   );

   // Pins are asynchronous: two flops before edge detection
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         sync1_q    <= '0;
         sync2_q    <= '0;
         sig_prev_q <= '0;
      end else begin
         sync1_q    <= ext_sig;
         sync2_q    <= sync1_q;
         sig_prev_q <= sync2_q;
      end
   end

   always_comb begin
      edge_hit = sync2_q[sel_q] & ~sig_prev_q[sel_q];
      st_d     = st_q;
      pos_d    = pos_q;
      tgt_d    = tgt_q;
      lat_d    = lat_q;
      spd_d    = spd_q;
      sel_d    = sel_q;
      stat_d   = stat_q;
      stat_d.cancel_done = 1'b0;
      diff     = tgt_q - pos_q;
      // Step is |speed| per cycle, sign from remaining distance
      step     = POS_W'(spd_q < 0 ? -spd_q : spd_q);
      if (cmd.cancel && st_q != EIFP_IDLE) begin
         st_d               = EIFP_IDLE;
         stat_d.busy        = 1'b0;
         stat_d.cancel_done = 1'b1;
      end else if (cmd.feed_cmd && cmd.latch_request_first && st_q == EIFP_IDLE) begin
         st_d        = EIFP_FEED;
         spd_d       = cmd.speed;
         sel_d       = cmd.latch_signal_select_first;
         stat_d.latch_complete_first    = 1'b0;
         stat_d.motion_output_done_flag = 1'b0;
         stat_d.busy = 1'b1;
      end else begin
         case (st_q)
            EIFP_FEED: begin
               if (edge_hit) begin
                  lat_d = pos_q;
                  stat_d.latch_complete_first = 1'b1;
                  tgt_d = pos_q + travel_dist;
                  st_d  = EIFP_POSN;
               end else if (tick) begin
                  pos_d = pos_q + POS_W'(spd_q);
               end
            end
            EIFP_POSN: begin
               if (diff == 0) begin
                  stat_d.motion_output_done_flag = 1'b1;
                  stat_d.busy = 1'b0;
                  st_d        = EIFP_IDLE;
               end else if (tick) begin
                  // Clamp last step so the reference never overshoots
                  if (diff > 0)
                     pos_d = (diff < step) ? tgt_q : pos_q + step;
                  else
                     pos_d = (-diff < step) ? tgt_q : pos_q - step;
               end
            end
            default: st_d = EIFP_IDLE;
         endcase
      end
   end

   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         st_q   <= EIFP_IDLE;
         pos_q  <= POS_RST;
         tgt_q  <= POS_RST;
         lat_q  <= POS_RST;
         spd_q  <= '0;
         sel_q  <= '0;
         stat_q <= '0;
      end else begin
         st_q   <= st_d;
         pos_q  <= pos_d;
         tgt_q  <= tgt_d;
         lat_q  <= lat_d;
         spd_q  <= spd_d;
         sel_q  <= sel_d;
         stat_q <= stat_d;
      end
   end

   always_comb begin
      stat        = stat_q;
      ref_pos     = pos_q;
      latched_pos = lat_q;
   end
endmodule
`default_nettype wire

// ### tb/eifp_feed_assertions.sv
`default_nettype none
module eifp_feed_assertions
   import eifp_pkg::*;
#(parameter int CYC_DIV = 2) (
   // Watched ports
   input wire logic               mclk,
   input wire logic               sys_rst,
   input wire eifp_cmd_t          cmd,
   input wire logic signed [31:0] travel_dist,
   input wire logic [3:0]         ext_sig,
   input wire eifp_stat_t         stat,
   input wire logic signed [31:0] ref_pos,
   input wire logic signed [31:0] latched_pos
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   wire logic bz = stat.busy;
   wire logic lc = stat.latch_complete_first;
   wire logic dn = stat.motion_output_done_flag;
   wire logic go = !bz && cmd.feed_cmd && cmd.latch_request_first && !cmd.cancel;
   AST_TAKEN: assert property (go |=> bz) else $error("feed lost");
   AST_CLEAR: assert property (go |=> !lc && !dn) else $error("stale flags");
   AST_SPEED: assert property (bz && !lc && $changed(ref_pos) |->
      ref_pos - $past(ref_pos) == cmd.speed) else $error("feed step");
   AST_LATCH: assert property (bz && !lc && !cmd.cancel &&
      $rose(ext_sig[cmd.latch_signal_select_first]) |-> ##[1:5] lc) else $error("no latch");
   AST_HOLD: assert property (lc && $past(lc) |-> $stable(latched_pos))
      else $error("latch moved");
   AST_TARGET: assert property ($rose(dn) |-> !bz &&
      ref_pos == latched_pos + travel_dist) else $error("wrong stop");
   // Steps only count once the latch has stood a cycle; earlier ones are still feed motion
   AST_POS: assert property (lc && $past(lc) && travel_dist > 0 && $changed(ref_pos) |->
      ref_pos > $past(ref_pos)) else $error("not positive");
   AST_NEG: assert property (lc && $past(lc) && travel_dist < 0 && $changed(ref_pos) |->
      ref_pos < $past(ref_pos)) else $error("not negative");
   AST_CANCEL: assert property (bz && cmd.cancel |=> !bz && stat.cancel_done)
      else $error("no stop");
   cover property ($rose(lc));
   cover property ($rose(dn));
   cover property (stat.cancel_done);
endmodule
bind eifp_feed eifp_feed_assertions #(.CYC_DIV(CYC_DIV)) u_chk (.mclk, .sys_rst, .cmd,
   .travel_dist, .ext_sig, .stat, .ref_pos, .latched_pos);
`default_nettype wire

// ### tb/eifp_master.sv
`default_nettype none
module eifp_master
   import eifp_pkg::*;
(
   // Command side toward the drive
   input wire logic           mclk,
   output var eifp_cmd_t      cmd,
   output var logic [31:0]    travel_dist
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      cmd = '0;
      travel_dist = '0;
   end
   task automatic feed(input logic [15:0] spd, input logic [1:0] sel, input logic [31:0] d);
      @(posedge mclk);
      cmd <= '{1'b1, 1'b0, 1'b1, sel, spd};
      travel_dist <= d;
      @(posedge mclk);
      cmd.feed_cmd <= 1'b0;
   endtask
   task automatic abort();
      @(posedge mclk);
      cmd.cancel <= 1'b1;
      @(posedge mclk);
      cmd.cancel <= 1'b0;
   endtask
endmodule
`default_nettype wire

// ### tb/eifp_feed_tb.sv
`default_nettype none
module eifp_feed_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import eifp_pkg::*;
   logic                    mclk = 1'b0;
   logic                    sys_rst = 1'b1;
   logic [3:0]              ext_sig = '0;
   eifp_cmd_t               cmd;
   eifp_stat_t              stat;
   logic signed [POS_W-1:0] travel_dist, ref_pos, latched_pos, p;
   int                      mismatches = 0;
   int                      checks_done = 0;
   `define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin mismatches++; \
      $display("unexpected t=%0t got %h exp %h", $time, (a), (b)); end end
   initial forever #5 mclk = ~mclk;
   eifp_master m (.mclk(mclk), .cmd(cmd), .travel_dist(travel_dist));
   // Short cycle keeps each move to a few tens of clocks
   eifp_feed #(.CYC_DIV(2)) dut (.mclk(mclk), .sys_rst(sys_rst), .cmd(cmd),
      .travel_dist(travel_dist), .ext_sig(ext_sig), .stat(stat), .ref_pos(ref_pos),
      .latched_pos(latched_pos));
   task automatic final_report();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   task automatic wait_bit(input int b);
      int n;
      for (n = 0; n < 3000 && stat[b] !== 1'b1; n++) @(negedge mclk);
      if (n == 3000) begin
         mismatches++;
         final_report();
      end
   endtask
   // Distances are whole steps of the speed so the stop point is exact
   task automatic run_move(input logic [15:0] s, input logic [1:0] sel, input logic [31:0] d);
      m.feed(s, sel, d);
      @(negedge mclk);
      `CHK(stat.busy, 1'b1)
      `CHK({stat.latch_complete_first, stat.motion_output_done_flag}, 2'b00)
      repeat (20) @(negedge mclk);
      @(posedge mclk) ext_sig[sel] <= 1'b1;
      wait_bit(3);
      wait_bit(2);
      `CHK(ref_pos, latched_pos + d)
      `CHK(stat.busy, 1'b0)
      @(posedge mclk) ext_sig <= '0;
   endtask
   task automatic t_dirs();
      run_move(16'sd3, 2'd1, 32'sd21);
      run_move(-16'sd2, 2'd2, 32'sd10);
      run_move(16'sd3, 2'd0, -32'sd15);
      run_move(-16'sd2, 2'd3, -32'sd8);
   endtask
   task automatic t_cancel();
      m.feed(16'sd4, 2'd0, 32'sd40);
      repeat (10) @(negedge mclk);
      m.abort();
      @(negedge mclk);
      `CHK(stat.busy, 1'b0)
      `CHK(stat.cancel_done, 1'b1)
      `CHK({stat.latch_complete_first, stat.motion_output_done_flag}, 2'b00)
      p = ref_pos;
      repeat (10) @(negedge mclk);
      `CHK(ref_pos, p)
      `CHK(stat.cancel_done, 1'b0)
   endtask
   initial begin
      repeat (20) @(posedge mclk);
      sys_rst <= 1'b0;
      t_dirs();
      t_cancel();
      final_report();
   end
endmodule
`default_nettype wire
